// *** verilog/asfs_seq.sv ***
// Serial frame sequencer of an eight-channel 8-bit converter
`timescale 1ns/10ps
`include "asfs_defines.svh"
// Operation
// - Track the input for three shift clocks, then hold and convert thirteen.
// - Result pin driven only while frame select is low, else released.
// - Shift clock is ignored whenever frame select is high.
// - Falls 1-4 send zeros, 5-12 the result MSB first, 13-16 zeros.
// - Back-to-back conversions: track again after each 16th rise, hold at 4th.
// - Frame opened with shift clock high: tracking starts at its first fall.
// - Frame opened with shift clock low: that opening is fall number one.
// - Frame select and shift clock falling together start tracking at once.
// - First 8 rises of each conversion load the control word for next one.
// - Control word bits 5..3 pick the input; other bits do nothing.
// - After power-up the first conversion is of input zero, no dummy.
// - Straight binary, step supply/256, first transition at half a step.
// - Powered while frame is open, off between 16th fall and next first.

module asfs_seq (
	input  wire logic       i_ref_clk,
	input  wire logic       i_rst,
	input  wire logic       i_shift_clk,
	input  wire logic       i_frame_sel_n,
	input  wire logic       i_cmd_in,
	input  wire logic       i_cmp_above,
	output logic            o_result_out,
	output logic            o_result_out_oe,
	output logic            o_track,
	output logic            o_power_on,
	output logic [2:0]      o_chan_sel,
	output logic [7:0]      o_dac_code,
	output logic [7:0]      o_result,
	output logic            o_result_valid,
	output logic            o_frame_active
);

	// ----------------------------------------------------------------
	// Gated link clocks and frame reset
	// ----------------------------------------------------------------
	// Falls are taken from shift clock OR frame select: a frame opened
	// with the clock low gives a fall at once, one opened with the
	// clock high waits for the clock, and a joint fall is one edge.
	// While the frame is closed this clock is held high and stands.
	logic fall_clk;
	logic link_clr;

	assign fall_clk = i_shift_clk | i_frame_sel_n;
	assign link_clr = i_rst | i_frame_sel_n;

	asfs_pkg::asfs_fall_s f_reg;
	asfs_pkg::asfs_fall_s f_next;
	asfs_pkg::asfs_rise_s r_reg;
	asfs_pkg::asfs_rise_s r_next;
	asfs_pkg::asfs_word_s w_reg;
	asfs_pkg::asfs_word_s w_next;
	asfs_pkg::asfs_sys_s  s_reg;
	asfs_pkg::asfs_sys_s  s_next;

	logic       sar_load;
	logic       sar_step;
	logic [7:0] sar_result;
	logic       sar_tgl;
	logic [1:0] sync_in;
	logic [1:0] sync_out;

	// ----------------------------------------------------------------
	// Falling-edge sequencer: position, phase and result bit
	// ----------------------------------------------------------------
	always_comb begin
		f_next = f_reg;
		if (!f_reg.started) begin
			f_next.started = 1'b1;
			f_next.pos     = 4'h0;
		end else begin
			f_next.pos = f_reg.pos + 4'h1;
		end
		f_next.track  = (f_next.pos < `ASFS_POS_HOLD);
		f_next.pd_gap = (f_next.pos == `ASFS_POS_LAST);
		if (f_next.pos == `ASFS_POS_LAST) begin
			f_next.phase = asfs_pkg::PH_GAP;
		end else if (f_next.track) begin
			f_next.phase = asfs_pkg::PH_TRACK;
		end else begin
			f_next.phase = asfs_pkg::PH_HOLD;
		end
		// Zeros around the data, result bits as they are decided
		if (f_next.pos >= `ASFS_POS_DATA_FIRST &&
		    f_next.pos <= `ASFS_POS_DATA_LAST) begin
			f_next.dout = i_cmp_above;
		end else begin
			f_next.dout = 1'b0;
		end
	end

	// Cleared while the frame is closed, so each frame starts at fall 1.
	// Frame select is tested itself, not through link_clr: opening the
	// frame with the clock low makes the first fall from the same change,
	// and a derived clear could still read high at that very edge.
	always_ff @(negedge fall_clk or posedge i_rst
	            or posedge i_frame_sel_n) begin
		if (i_rst || i_frame_sel_n) begin
			f_reg <= '0;
		end else begin
			f_reg <= f_next;
		end
	end

	// SAR strobes follow the next position of the sequencer
	assign sar_load = (f_next.pos == `ASFS_POS_HOLD);
	assign sar_step = (f_next.pos >= `ASFS_POS_DATA_FIRST) &&
	                  (f_next.pos <= `ASFS_POS_DATA_LAST);

	asfs_sar u_sar (
		.i_clk_fall  (fall_clk),
		.i_rst       (i_rst),
		.i_load      (sar_load),
		.i_step      (sar_step),
		.i_cmp_above (i_cmp_above),
		.o_dac_code  (o_dac_code),
		.o_result    (sar_result),
		.o_done_tgl  (sar_tgl)
	);

	// ----------------------------------------------------------------
	// Rising-edge side: control word capture
	// ----------------------------------------------------------------
	// Rise position wraps every 16 rises; only the first 8 shift in.
	always_comb begin
		logic [7:0] word_in;
		word_in = {w_reg.word[6:0], i_cmd_in};
		r_next  = r_reg;
		w_next  = w_reg;
		r_next.rpos = r_reg.rpos + 4'h1;
		// Frame select gates the capture, so the flops need no enable
		if (!i_frame_sel_n && r_reg.rpos <= `ASFS_CTRL_LAST_POS) begin
			w_next.word = word_in;
		end
		if (!i_frame_sel_n && r_reg.rpos == `ASFS_CTRL_LAST_POS) begin
			// Channel changes during hold, so the held sample is safe
			w_next.chan = word_in[`ASFS_CHAN_SEL_HI:`ASFS_CHAN_SEL_LO];
		end
	end

	// Frame-scoped counter, cleared whenever frame select is high
	always_ff @(posedge i_shift_clk or posedge link_clr) begin
		if (link_clr) begin
			r_reg <= '0;
		end else begin
			r_reg <= r_next;
		end
	end

	// Channel survives between frames; power-up selects input zero
	always_ff @(posedge i_shift_clk or posedge i_rst) begin
		if (i_rst) begin
			w_reg.word <= `ASFS_WORD_RESET;
			w_reg.chan <= `ASFS_CHAN_RESET;
		end else begin
			w_reg <= w_next;
		end
	end

	// ----------------------------------------------------------------
	// Link-side outputs
	// ----------------------------------------------------------------
	// Enable and power follow frame select without waiting for a clock
	// edge; a clocked copy would leave the pin driving after close.
	assign o_result_out    = f_reg.dout;
	assign o_result_out_oe = ~i_frame_sel_n;
	assign o_track         = f_reg.track;
	assign o_power_on      = ~i_frame_sel_n & ~f_reg.pd_gap;
	assign o_chan_sel      = w_reg.chan;

	// ----------------------------------------------------------------
	// Crossing into the reference clock
	// ----------------------------------------------------------------
	// Result word is stable for a whole conversion after its toggle,
	// far longer than the two-flop delay of the toggle.
	assign sync_in[0] = ~i_frame_sel_n;
	assign sync_in[1] = sar_tgl;

	genvar gi;
	generate
		for (gi = 0; gi < 2; gi = gi + 1) begin : g_sync
			asfs_sync_bit u_sync (
				.i_clk (i_ref_clk),
				.i_rst (i_rst),
				.i_d   (sync_in[gi]),
				.o_q   (sync_out[gi])
			);
		end
	endgenerate

	// System-side capture of each finished result
	always_comb begin
		s_next       = s_reg;
		s_next.valid = 1'b0;
		s_next.frame = sync_out[0];
		if (sync_out[1] != s_reg.tgl_seen) begin
			s_next.tgl_seen = sync_out[1];
			s_next.result   = sar_result;
			s_next.valid    = 1'b1;
		end
	end

	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			s_reg <= '0;
		end else begin
			s_reg <= s_next;
		end
	end

	assign o_result       = s_reg.result;
	assign o_result_valid = s_reg.valid;
	assign o_frame_active = s_reg.frame;

	// ----------------------------------------------------------------
	// Checks on the falling-edge sequencer
	// ----------------------------------------------------------------
	property p_track_three;
		@(negedge fall_clk) disable iff (link_clr)
		$fell(f_reg.track) |-> $past(f_reg.track, 3) &&
		                       (f_reg.pos == 4'h3);
	endproperty
	a_track_three: assert property (p_track_three)
		else $error("tracking did not last three clocks");

	property p_zero_pad;
		@(negedge fall_clk) disable iff (link_clr)
		f_reg.started && (f_reg.pos < 4'h4 || f_reg.pos > 4'hB)
		|-> !f_reg.dout;
	endproperty
	a_zero_pad: assert property (p_zero_pad)
		else $error("result pin not zero outside data bits");

	property p_data_bits;
		@(negedge fall_clk) disable iff (link_clr)
		(f_reg.pos == 4'hB) && f_reg.started
		|-> sar_result[0] == f_reg.dout;
	endproperty
	a_data_bits: assert property (p_data_bits)
		else $error("last data bit differs from result");

	property p_retrack;
		@(negedge fall_clk) disable iff (link_clr)
		f_reg.started && (f_reg.pos == 4'hF)
		|=> f_reg.track && (f_reg.pos == 4'h0) ##3 !f_reg.track;
	endproperty
	a_retrack: assert property (p_retrack)
		else $error("no new tracking after sixteenth clock");

	property p_first_fall;
		@(negedge fall_clk) disable iff (link_clr)
		!f_reg.started |=> f_reg.track && (f_reg.pos == 4'h0);
	endproperty
	a_first_fall: assert property (p_first_fall)
		else $error("first fall of frame did not start tracking");

	property p_power_gap;
		@(negedge fall_clk) disable iff (link_clr)
		f_reg.pd_gap |-> (f_reg.pos == 4'hF) && !o_power_on
		##1 o_power_on;
	endproperty
	a_power_gap: assert property (p_power_gap)
		else $error("power gap misplaced");

	// ----------------------------------------------------------------
	// Checks on the rising-edge side and the pin
	// ----------------------------------------------------------------
	property p_ctrl_word;
		@(posedge i_shift_clk) disable iff (link_clr)
		(r_reg.rpos == 4'h8) |-> o_chan_sel ==
		{$past(i_cmd_in, 6), $past(i_cmd_in, 5), $past(i_cmd_in, 4)};
	endproperty
	a_ctrl_word: assert property (p_ctrl_word)
		else $error("channel not taken from control bits 5..3");

	property p_ignore_idle;
		@(posedge i_shift_clk) disable iff (i_rst)
		i_frame_sel_n |=> $stable(w_reg) || !$past(i_frame_sel_n);
	endproperty
	a_ignore_idle: assert property (p_ignore_idle)
		else $error("shift clock acted while frame closed");

	property p_pin_enable;
		@(posedge i_ref_clk) disable iff (i_rst)
		s_reg.frame && $past(s_reg.frame) |-> o_result_out_oe ||
		$past(i_frame_sel_n) || i_frame_sel_n;
	endproperty
	a_pin_enable: assert property (p_pin_enable)
		else $error("result pin released inside frame");

	// ----------------------------------------------------------------
	// Checks on data order, hold start, control word capture and the closed frame
	// ----------------------------------------------------------------
	// These look at the trial code and the word register themselves,
	// so a slip of one edge between sequencer and SAR, or a late shift
	// into the word, shows up here and not only on the pin.

	// Each data bit on the pin is the bit the SAR has just decided
	property p_msb_first;
		@(negedge fall_clk) disable iff (link_clr)
		f_reg.started && (f_reg.pos >= 4'h4) && (f_reg.pos <= 4'hB)
		|-> f_reg.dout == o_dac_code[3'(4'hB - f_reg.pos)];
	endproperty
	a_msb_first: assert property (p_msb_first)
		else $error("result bit does not follow the decided trial bit");

	// Hold begins at fall 4 with the search at mid scale
	property p_hold_start;
		@(negedge fall_clk) disable iff (link_clr)
		f_reg.started && (f_reg.pos == 4'h3)
		|-> (f_reg.phase == asfs_pkg::PH_HOLD) && (o_dac_code == 8'h80);
	endproperty
	a_hold_start: assert property (p_hold_start)
		else $error("hold did not start at fall four");

	// No shift into the word after rise 8 of a conversion
	property p_word_quiet;
		@(posedge i_shift_clk) disable iff (link_clr)
		(r_reg.rpos > 4'h8) |-> $stable(w_reg.word);
	endproperty
	a_word_quiet: assert property (p_word_quiet)
		else $error("control word moved after its eighth bit");

	// Channel moves only at rise 8; rise 1 compares across frames
	property p_chan_hold;
		@(posedge i_shift_clk) disable iff (link_clr)
		(r_reg.rpos != 4'h0) && (r_reg.rpos != 4'h8)
		|-> $stable(o_chan_sel);
	endproperty
	a_chan_hold: assert property (p_chan_hold)
		else $error("channel changed away from rise eight");

	// Closed frame leaves no tracking and a quiet result bit
	property p_idle_clear;
		@(posedge i_ref_clk) disable iff (i_rst)
		i_frame_sel_n |-> !o_track && !o_result_out;
	endproperty
	a_idle_clear: assert property (p_idle_clear)
		else $error("frame state left over while frame closed");

endmodule

// *** verilog/asfs_defines.svh ***
// Constants of the serial frame sequencer: positions, counts, reset values
`ifndef ASFS_DEFINES_SVH
`define ASFS_DEFINES_SVH

// ----------------------------------------------------------------
// Conversion timing, in shift-clock falling edges (position = edge - 1)
// ----------------------------------------------------------------
`define ASFS_CONV_EDGES     16
`define ASFS_TRACK_EDGES    3
`define ASFS_POS_HOLD       4'h3
`define ASFS_POS_DATA_FIRST 4'h4
`define ASFS_POS_DATA_LAST  4'hB
`define ASFS_POS_LAST       4'hF

// ----------------------------------------------------------------
// Control word layout and reset values
// ----------------------------------------------------------------
`define ASFS_CTRL_BITS      8
`define ASFS_CTRL_LAST_POS  4'h7
`define ASFS_CHAN_SEL_HI    5
`define ASFS_CHAN_SEL_LO    3
`define ASFS_CHAN_RESET     3'h0
`define ASFS_WORD_RESET     8'h00
`define ASFS_SAR_FIRST      8'h80
`define ASFS_SAR_TOP_BIT    3'h7

`endif

// *** verilog/asfs_pkg.sv ***
// Types of the serial frame sequencer
package asfs_pkg;

	// ----------------------------------------------------------------
	// Phase of the converter within a conversion
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		PH_IDLE  = 2'b00,
		PH_TRACK = 2'b01,
		PH_HOLD  = 2'b10,
		PH_GAP   = 2'b11
	} asfs_phase_e;

	// Falling-edge domain, cleared whenever the frame is closed
	typedef struct packed {
		logic        started;
		logic [3:0]  pos;
		asfs_phase_e phase;
		logic        track;
		logic        dout;
		logic        pd_gap;
	} asfs_fall_s;

	// Rising-edge domain, cleared whenever the frame is closed
	typedef struct packed {
		logic [3:0] rpos;
	} asfs_rise_s;

	// Rising-edge domain, kept across frames
	typedef struct packed {
		logic [7:0] word;
		logic [2:0] chan;
	} asfs_word_s;

	// Successive-approximation register
	typedef struct packed {
		logic [7:0] trial;
		logic [2:0] bitn;
		logic       busy;
		logic [7:0] result;
		logic       tgl;
	} asfs_sar_s;

	// System-clock side
	typedef struct packed {
		logic       tgl_seen;
		logic [7:0] result;
		logic       valid;
		logic       frame;
	} asfs_sys_s;

	// Two-stage synchroniser
	typedef struct packed {
		logic meta;
		logic q;
	} asfs_sync_s;

endpackage

// *** verilog/asfs_sync_bit.sv ***
// Two-flop synchroniser for one level
`timescale 1ns/10ps

module asfs_sync_bit (
	input  wire logic i_clk,
	input  wire logic i_rst,
	input  wire logic i_d,
	output logic      o_q
);

	asfs_pkg::asfs_sync_s s_reg;
	asfs_pkg::asfs_sync_s s_next;

	// ----------------------------------------------------------------
	// Stages: first stage is read only by the second
	// ----------------------------------------------------------------
	always_comb begin
		s_next      = s_reg;
		s_next.meta = i_d;
		s_next.q    = s_reg.meta;
	end

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			s_reg <= '0;
		end else begin
			s_reg <= s_next;
		end
	end

	assign o_q = s_reg.q;

endmodule

// *** verilog/asfs_sar.sv ***
// Successive-approximation register stepped by shift-clock falls
`timescale 1ns/10ps
`include "asfs_defines.svh"

module asfs_sar (
	input  wire logic       i_clk_fall,
	input  wire logic       i_rst,
	input  wire logic       i_load,
	input  wire logic       i_step,
	input  wire logic       i_cmp_above,
	output logic [7:0]      o_dac_code,
	output logic [7:0]      o_result,
	output logic            o_done_tgl
);

	asfs_pkg::asfs_sar_s s_reg;
	asfs_pkg::asfs_sar_s s_next;

	// ----------------------------------------------------------------
	// Bit search: keep the trial bit when the held input is above it
	// ----------------------------------------------------------------
	// The DAC places code c at c - 1/2 step, so the first transition
	// sits at half a step and the rest one step apart.
	always_comb begin
		s_next = s_reg;
		if (i_load) begin
			s_next.trial = `ASFS_SAR_FIRST;
			s_next.bitn  = `ASFS_SAR_TOP_BIT;
			s_next.busy  = 1'b1;
		end else if (i_step && s_reg.busy) begin
			s_next.trial[s_reg.bitn] = i_cmp_above;
			if (s_reg.bitn == 3'h0) begin
				s_next.result = {s_reg.trial[7:1], i_cmp_above};
				s_next.busy   = 1'b0;
				s_next.tgl    = ~s_reg.tgl;
			end else begin
				s_next.trial[s_reg.bitn - 3'h1] = 1'b1;
				s_next.bitn = s_reg.bitn - 3'h1;
			end
		end
	end

	// Result and toggle survive frame close; only power-up clears them
	always_ff @(negedge i_clk_fall or posedge i_rst) begin
		if (i_rst) begin
			s_reg <= '0;
		end else begin
			s_reg <= s_next;
		end
	end

	assign o_dac_code = s_reg.trial;
	assign o_result   = s_reg.result;
	assign o_done_tgl = s_reg.tgl;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	property p_sar_start;
		@(negedge i_clk_fall) disable iff (i_rst)
		i_load |=> (o_dac_code == 8'h80) && s_reg.busy;
	endproperty
	a_sar_start: assert property (p_sar_start)
		else $error("search does not start at mid scale");

endmodule

// *** bench/asfs_host_model.sv ***
// Host master model driving the serial link of the frame sequencer
`timescale 1ns/10ps

module asfs_host_model (
	output logic      o_shift_clk,
	output logic      o_frame_sel_n,
	output logic      o_cmd_in,
	input  wire logic i_result_pin
);
	localparam int HALF = 16;

	// Idle link: frame closed, clock parked high
	initial begin
		o_shift_clk = 1'b1;
		o_frame_sel_n = 1'b1;
		o_cmd_in = 1'b0;
	end

	// ----------------------------------------------------------------
	// Frame of n conversions
	// ----------------------------------------------------------------
	// Mode 0 opens with clock high, 1 with clock low, 2 drops both at once
	task automatic frame(input int mode, input int n,
		input logic [31:0] words, output logic [63:0] res);
		int         k;
		logic [7:0] w;
		res = '0;
		o_shift_clk = (mode != 1);
		#HALF;
		o_frame_sel_n = 1'b0;
		if (mode == 2) begin
			o_shift_clk = 1'b0;
		end
		if (mode == 0) begin
			#HALF;
			o_shift_clk = 1'b0;
		end
		// Whole groups of 16 rises only, never a partial one
		for (k = 0; k < 16 * n; k++) begin
			w = words[8 * (k / 16) +: 8];
			// Past bit 0 the line keeps toggling so it is never quiet
			o_cmd_in = (k % 16 < 8) ? w[7 - k % 16] : ~o_cmd_in;
			#HALF;
			o_shift_clk = 1'b1;
			res = {res[62:0], i_result_pin};
			#HALF;
			if (k < 16 * n - 1) begin
				o_shift_clk = 1'b0;
			end
		end
		o_frame_sel_n = 1'b1;
		o_cmd_in = ~o_cmd_in;
	endtask

	// Clock activity with the frame closed, which must be ignored
	task automatic idle_toggle(input int n);
		repeat (n) begin
			#HALF;
			o_shift_clk = 1'b0;
			o_cmd_in = ~o_cmd_in;
			#HALF;
			o_shift_clk = 1'b1;
		end
	endtask
endmodule

// *** bench/test_asfs_seq.sv ***
// Self-checking testbench of the serial frame sequencer
`timescale 1ns/10ps

module test_asfs_seq;
	logic       i_ref_clk;
	logic       i_rst;
	logic       shift_clk;
	logic       frame_sel_n;
	logic       cmd_in;
	logic       cmp_above;
	logic       result_out;
	logic       result_out_oe;
	logic       track;
	logic       power_on;
	logic [2:0] chan_sel;
	logic [7:0] dac_code;
	logic [7:0] result;
	logic       result_valid;
	logic       frame_active;
	wire        result_pin;
	logic [7:0] levels [8];
	logic [7:0] held;
	logic [7:0] exp_q [$];
	int         error_cnt;
	int         checked;
	int         rise_cnt;
	int         pos;

	asfs_seq dut_u (
		.i_ref_clk       (i_ref_clk),
		.i_rst           (i_rst),
		.i_shift_clk     (shift_clk),
		.i_frame_sel_n   (frame_sel_n),
		.i_cmd_in        (cmd_in),
		.i_cmp_above     (cmp_above),
		.o_result_out    (result_out),
		.o_result_out_oe (result_out_oe),
		.o_track         (track),
		.o_power_on      (power_on),
		.o_chan_sel      (chan_sel),
		.o_dac_code      (dac_code),
		.o_result        (result),
		.o_result_valid  (result_valid),
		.o_frame_active  (frame_active)
	);

	asfs_host_model host_u (
		.o_shift_clk   (shift_clk),
		.o_frame_sel_n (frame_sel_n),
		.o_cmd_in      (cmd_in),
		.i_result_pin  (result_pin)
	);

	// ----------------------------------------------------------------
	// Analog core stand-in: levels are ideal codes, held at end of track
	// ----------------------------------------------------------------
	assign result_pin = result_out_oe ? result_out : 1'bz;
	assign cmp_above = (held >= dac_code);
	always @(negedge track) held = levels[chan_sel];

	always #25 i_ref_clk = ~i_ref_clk;

	task automatic check(input string what, input logic [15:0] seen,
		input logic [15:0] exp);
		checked++;
		if (seen !== exp) begin
			error_cnt++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic report_and_stop();
		$display("comparisons %0d mismatches %0d", checked, error_cnt);
		if (error_cnt == 0 && checked > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	// Phase, power and pin enable at every rise inside a frame
	always @(posedge shift_clk or posedge frame_sel_n) begin
		if (frame_sel_n) begin
			rise_cnt = 0;
		end else begin
			rise_cnt++;
			pos = (rise_cnt - 1) % 16 + 1;
			check("track", track, pos <= 3);
			check("power", power_on, pos != 16);
			check("pin enable", result_out_oe, 1'b1);
			if (pos == 4)
				check("dac start", dac_code, 8'h80);
			if (pos == 16)
				check("frame flag open", frame_active, 1'b1);
		end
	end

	// Results on the system side arrive in conversion order
	always @(posedge i_ref_clk) begin
		if (result_valid === 1'b1) begin
			if (exp_q.size() == 0)
				check("unexpected result", 1'b1, 1'b0);
			else
				check("result", result, exp_q.pop_front());
		end
	end

	// ----------------------------------------------------------------
	// One frame with expectations worked out from the control words
	// ----------------------------------------------------------------
	task automatic run(input int mode, input int n, input logic [31:0] words,
		input logic [2:0] first_chan);
		logic [63:0] res;
		logic [2:0]  ch;
		int          i;
		ch = first_chan;
		for (i = 0; i < n; i++) begin
			exp_q.push_back(levels[ch]);
			ch = words[8 * i + 3 +: 3];
		end
		host_u.frame(mode, n, words, res);
		ch = first_chan;
		for (i = 0; i < n; i++) begin
			check("pin word", res[16 * (n - 1 - i) +: 16],
				{4'h0, levels[ch], 4'h0});
			ch = words[8 * i + 3 +: 3];
		end
		check("channel", chan_sel, ch);
		repeat (8) @(posedge i_ref_clk);
		check("pending results", 16'(exp_q.size()), 16'h0000);
		check("pin released", result_out_oe, 1'b0);
		check("frame flag", frame_active, 1'b0);
		$display("frame mode %0d with %0d conversions done", mode, n);
	endtask

	// Tests: one to four conversions per frame, all three opening styles
	initial begin
		i_ref_clk = 1'b0;
		i_rst <= 1'b1;
		held = 8'h00;
		error_cnt = 0;
		checked = 0;
		rise_cnt = 0;
		levels = '{8'hA5, 8'h00, 8'h7F, 8'h80, 8'hFF, 8'h3C, 8'hC3, 8'h5A};
		repeat (2) @(posedge i_ref_clk);
		i_rst <= 1'b0;
		repeat (3) @(posedge i_ref_clk);
		run(0, 1, 32'h0000_00EB, 3'h0);
		host_u.idle_toggle(20);
		check("idle channel", chan_sel, 3'h5);
		run(1, 3, 32'h00C7_38DF, 3'h5);
		run(2, 3, 32'h00FF_0824, 3'h0);
		run(0, 4, 32'h1020_3000, 3'h7);
		@(posedge i_ref_clk);
		i_rst <= 1'b1;
		repeat (2) @(posedge i_ref_clk);
		i_rst <= 1'b0;
		@(posedge i_ref_clk);
		check("channel after reset", chan_sel, 3'h0);
		run(1, 1, 32'h0000_0010, 3'h0);
		report_and_stop();
	end

	// Watchdog well beyond the few microseconds the frames take
	initial begin
		#50000;
		error_cnt++;
		$display("watchdog expired");
		report_and_stop();
	end
endmodule
